/* File: verilog/sarc_defines.svh */
/*
  Constants of the converter control block: register offsets, field
  positions, reset values, encodings and sequencing counts.
  Assumes inclusion by bare name from the package and the design modules.
*/
// Summary of operation
// [R1] Justify/shift 000 gives right-justified; 100 puts the 10-bit code at 15:6.
// [R2] Single sample stores a 10-bit unsigned code, all unused bits zero.
// [R3] Repeat above one sums 4 to 64 samples; result updates after the last.
// [R4] Sample count comes from the repeat-count field of accumulator config.
// [R5] Software keeps right justification whenever repeat count exceeds one.
// [R6] A 16-bit accumulator, shifted right one to three places when selected.
// [R7] Conversion clock divides system clock, or low-power oscillator in burst.
// [R8] Start source: busy write, timer 0/2/3 overflow, or external pin rise.
// [R9] Busy bit stays one for the whole conversion, then returns to zero.
// [R10] Busy falling sets the done flag; result valid while it reads one.
// [R11] Software polls the done flag, not the busy bit.
// [R12] Timers 2/3 trigger on low-byte overflow in 8-bit mode, else high-byte.
// [R13] Software makes the port skip the external start pin when used.
// [R14] Inside mode flags results strictly between the two thresholds.
// [R15] Outside mode flags results strictly below greater-than or above less-than.
// [R16] Justify/shift 001, 010, 011 shift right by one, two, three bits.
// [R17] A control bit picks inside or outside window; compare formatted word.
`ifndef SARC_DEFINES_SVH
`define SARC_DEFINES_SVH
`define SARC_ADDR_CONTROL 8'h00
`define SARC_ADDR_CONFIG 8'h04
`define SARC_ADDR_ACCUM 8'h08
`define SARC_ADDR_RESULT 8'h0C
`define SARC_ADDR_GT 8'h10
`define SARC_ADDR_LT 8'h14
`define SARC_CTL_MODE_LSB 0
`define SARC_CTL_WINSEL 3
`define SARC_CTL_BUSY 4
`define SARC_CTL_WINFLAG 5
`define SARC_CTL_DONE 6
`define SARC_CFG_DIV_LSB 0
`define SARC_CFG_BURST 8
`define SARC_ACC_SJST_LSB 0
`define SARC_ACC_RPT_LSB 3
`define SARC_RST_MODE 3'h0
`define SARC_RST_DIV 5'h04
`define SARC_RST_SJST 3'h0
`define SARC_RST_RPT 3'h0
`define SARC_RST_GT 16'hFFFF
`define SARC_RST_LT 16'h0000
`define SARC_SJST_LEFT 3'h4
`define SARC_CONV_TICKS 5'h0C
`define SARC_MODE_SOFT 3'h0
`define SARC_MODE_TMR0 3'h1
`define SARC_MODE_TMR2 3'h2
`define SARC_MODE_TMR3 3'h3
`define SARC_MODE_EXT 3'h4
`endif

/* File: verilog/sarc_pkg.sv */
/*
  Types of the converter control block.
  Assumes the constants header is on the include path.
*/
`include "sarc_defines.svh"
package sarc_pkg;
  typedef enum logic [1:0] {
    SARC_IDLE = 2'b01,
    SARC_CONV = 2'b10
  } sarc_state_e;
  typedef logic [2:0] sarc_mode_t;
  typedef logic [15:0] sarc_word_t;
endpackage : sarc_pkg

/* File: verilog/sarc_fmt_if.sv */
/*
  Carries the raw sum and format settings to the formatter and the
  formatted word and window verdict back.
  Assumes one producer and one formatter, both on one clock.
*/
interface sarc_fmt_if;
  logic [15:0] sum;
  logic [2:0] justShift;
  logic [15:0] gtThr;
  logic [15:0] ltThr;
  logic winOutside;
  logic [15:0] result;
  logic winHit;
  modport src (output sum, justShift, gtThr, ltThr, winOutside,
    input result, winHit);
  modport fmt (input sum, justShift, gtThr, ltThr, winOutside,
    output result, winHit);
endinterface : sarc_fmt_if

/* File: verilog/sarc_format.sv */
/*
  Formats the accumulated sum into the result word and checks it
  against the window thresholds. Purely combinational.
  Assumes the sum holds a single 10-bit code when one sample is taken.
*/
`include "sarc_defines.svh"
module sarc_format (
  // Sum in, formatted word out
  sarc_fmt_if.fmt fi
);
  import sarc_pkg::*;

  always_comb begin
    if (fi.justShift == `SARC_SJST_LEFT) begin
      fi.result = {fi.sum[9:0], 6'h00}; // see [R1]
    end else begin
      fi.result = fi.sum >> fi.justShift[1:0]; // see [R6] see [R16] see [R1]
    end
  end

  always_comb begin
    if (fi.winOutside) begin
      fi.winHit = (fi.result < fi.gtThr) || (fi.result > fi.ltThr); // see [R15]
    end else begin
      fi.winHit = (fi.result > fi.gtThr) && (fi.result < fi.ltThr); // see [R14]
    end
  end
endmodule : sarc_format

/* File: verilog/sarc_clkdiv.sv */
/*
  Conversion clock divider. Counts system clocks, or low-power
  oscillator edges in burst mode, and wraps every divider+1 events.
  Assumes lpTick is already synchronised to clk_sys.
*/
module sarc_clkdiv (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Control
  input wire logic run,
  input wire logic burst,
  input wire logic [4:0] divider,
  input wire logic lpTick,
  // Output
  output logic tick,
  output logic convClk
);
  import sarc_pkg::*;
  logic [4:0] cnt;
  logic [4:0] next_cnt;
  logic next_tick;
  logic next_convClk;
  logic srcEvent;

  always_comb begin
    srcEvent = burst ? lpTick : 1'b1; // see [R7]
    next_cnt = cnt;
    next_tick = 1'b0;
    next_convClk = convClk;
    if (!run) begin
      next_cnt = 5'h00;
      next_convClk = 1'b0;
    end else if (srcEvent) begin
      if (cnt == divider) begin
        next_cnt = 5'h00;
        next_convClk = ~convClk;
        next_tick = ~convClk;
      end else begin
        next_cnt = cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cnt <= 5'h00;
      tick <= 1'b0;
      convClk <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= next_tick;
      convClk <= next_convClk;
    end
  end
endmodule : sarc_clkdiv

/* File: verilog/sarc_top.sv */
/*
  Converter control block top: APB register slave, start source
  selection, conversion sequencer, accumulator and result capture.
  Assumes the analogue core presents a stable 10-bit code at the end
  of each conversion on clk_sys; timer overflows are clk_sys pulses;
  the external start and low-power oscillator arrive asynchronously.
*/
`include "sarc_defines.svh"
module sarc_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Start sources
  input wire logic timer0Ovf,
  input wire logic timer2LowOvf,
  input wire logic timer2HighOvf,
  input wire logic timer2Split,
  input wire logic timer3LowOvf,
  input wire logic timer3HighOvf,
  input wire logic timer3Split,
  input wire logic externalStartInput,
  // Low-power oscillator
  input wire logic lpOscIn,
  // Analogue core
  input wire logic [9:0] adcCode,
  output logic convStart,
  output logic conversionClock,
  // Status
  output logic conversionBusyBit,
  output logic conversionDoneFlag,
  output logic windowMatchFlag
);
  import sarc_pkg::*;

  sarc_fmt_if fmtBus ();

  // Configuration registers
  sarc_mode_t startMode;
  sarc_mode_t next_startMode;
  logic winOutside;
  logic next_winOutside;
  logic [4:0] clockDividerField;
  logic [4:0] next_clockDividerField;
  logic burstModeEnable;
  logic next_burstModeEnable;
  logic [2:0] justifyShiftField;
  logic [2:0] next_justifyShiftField;
  logic [2:0] repeatCountField;
  logic [2:0] next_repeatCountField;
  sarc_word_t gtThr;
  sarc_word_t next_gtThr;
  sarc_word_t ltThr;
  sarc_word_t next_ltThr;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic next_conversionDoneFlag;
  logic next_windowMatchFlag;

  // Sequencer state
  sarc_state_e state;
  sarc_state_e next_state;
  logic [4:0] tickCnt;
  logic [4:0] next_tickCnt;
  logic [6:0] sampleCnt;
  logic [6:0] next_sampleCnt;
  sarc_word_t accum;
  sarc_word_t next_accum;
  sarc_word_t result;
  sarc_word_t next_result;
  logic next_convStart;
  logic next_conversionBusyBit;

  // Synchronisers and edge detectors
  logic extMeta;
  logic extSync;
  logic extLast;
  logic lpMeta;
  logic lpSync;
  logic lpLast;

  logic access;
  logic wrAccess;
  logic softStart;
  logic trigger;
  logic convTick;
  logic lastTick;
  logic lastSample;
  logic setDone;
  logic setWindow;
  logic extRise;
  logic lpTick;

  function automatic logic [6:0] sample_total(input logic [2:0] rpt);
    logic [6:0] n;
    n = 7'h01;
    unique case (rpt)
      3'h1: n = 7'h04;
      3'h2: n = 7'h08;
      3'h3: n = 7'h10;
      3'h4: n = 7'h20;
      3'h5: n = 7'h40;
      default: n = 7'h01;
    endcase
    return n;
  endfunction : sample_total

  sarc_clkdiv u_clkdiv (
    .clk_sys(clk_sys),
    .reset(reset),
    .run(state == SARC_CONV),
    .burst(burstModeEnable),
    .divider(clockDividerField),
    .lpTick(lpTick),
    .tick(convTick),
    .convClk(conversionClock)
  );

  sarc_format u_format (
    .fi(fmtBus)
  );

  assign fmtBus.sum = accum + {6'h00, adcCode}; // see [R3] see [R2]
  assign fmtBus.justShift = justifyShiftField;
  assign fmtBus.gtThr = gtThr;
  assign fmtBus.ltThr = ltThr;
  assign fmtBus.winOutside = winOutside; // see [R17]

  // Pin inputs pass two flops before use
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      extMeta <= 1'b0;
      extSync <= 1'b0;
      extLast <= 1'b0;
      lpMeta <= 1'b0;
      lpSync <= 1'b0;
      lpLast <= 1'b0;
    end else begin
      extMeta <= externalStartInput;
      extSync <= extMeta;
      extLast <= extSync;
      lpMeta <= lpOscIn;
      lpSync <= lpMeta;
      lpLast <= lpSync;
    end
  end

  assign extRise = extSync & ~extLast;
  assign lpTick = lpSync & ~lpLast;

  // Bus decode
  assign access = psel & penable & pready;
  assign wrAccess = access & pwrite;
  assign softStart = wrAccess && (paddr == `SARC_ADDR_CONTROL) &&
    pwdata[`SARC_CTL_BUSY];

  // Start source selection
  always_comb begin
    unique case (startMode)
      `SARC_MODE_SOFT: trigger = softStart; // see [R8]
      `SARC_MODE_TMR0: trigger = timer0Ovf; // see [R8]
      `SARC_MODE_TMR2:
        trigger = timer2Split ? timer2LowOvf : timer2HighOvf; // see [R12]
      `SARC_MODE_TMR3:
        trigger = timer3Split ? timer3LowOvf : timer3HighOvf; // see [R12]
      `SARC_MODE_EXT: trigger = extRise; // see [R8] see [R13]
      default: trigger = 1'b0;
    endcase
  end

  // Sequencer
  assign lastTick = convTick && (tickCnt == `SARC_CONV_TICKS - 5'h01);
  assign lastSample = lastTick &&
    (sampleCnt == sample_total(repeatCountField) - 7'h01); // see [R4]
  assign setDone = lastSample;
  assign setWindow = lastSample && fmtBus.winHit;

  always_comb begin
    next_state = state;
    next_tickCnt = tickCnt;
    next_sampleCnt = sampleCnt;
    next_accum = accum;
    next_result = result;
    next_convStart = 1'b0;
    next_conversionBusyBit = conversionBusyBit;
    unique case (state)
      SARC_IDLE: begin
        if (trigger) begin
          next_state = SARC_CONV;
          next_tickCnt = 5'h00;
          next_sampleCnt = 7'h00;
          next_accum = 16'h0000;
          next_convStart = 1'b1;
          next_conversionBusyBit = 1'b1; // see [R9]
        end
      end
      SARC_CONV: begin
        if (lastSample) begin
          next_state = SARC_IDLE;
          next_result = fmtBus.result; // see [R3] see [R2]
          next_conversionBusyBit = 1'b0; // see [R9]
        end else if (lastTick) begin
          next_tickCnt = 5'h00;
          next_sampleCnt = sampleCnt + 7'h01;
          next_accum = fmtBus.sum; // see [R3] see [R6]
          next_convStart = 1'b1;
        end else if (convTick) begin
          next_tickCnt = tickCnt + 5'h01;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= SARC_IDLE;
      tickCnt <= 5'h00;
      sampleCnt <= 7'h00;
      accum <= 16'h0000;
      result <= 16'h0000;
      convStart <= 1'b0;
      conversionBusyBit <= 1'b0;
    end else begin
      state <= next_state;
      tickCnt <= next_tickCnt;
      sampleCnt <= next_sampleCnt;
      accum <= next_accum;
      result <= next_result;
      convStart <= next_convStart;
      conversionBusyBit <= next_conversionBusyBit;
    end
  end

  // Register file and APB answer
  always_comb begin
    next_startMode = startMode;
    next_winOutside = winOutside;
    next_clockDividerField = clockDividerField;
    next_burstModeEnable = burstModeEnable;
    next_justifyShiftField = justifyShiftField;
    next_repeatCountField = repeatCountField;
    next_gtThr = gtThr;
    next_ltThr = ltThr;
    next_conversionDoneFlag = conversionDoneFlag;
    next_windowMatchFlag = windowMatchFlag;
    next_pready = psel & penable & ~pready;
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (wrAccess) begin
      unique case (paddr)
        `SARC_ADDR_CONTROL: begin
          next_startMode = pwdata[`SARC_CTL_MODE_LSB +: 3];
          next_winOutside = pwdata[`SARC_CTL_WINSEL];
          if (!pwdata[`SARC_CTL_DONE]) begin
            next_conversionDoneFlag = 1'b0;
          end
          if (!pwdata[`SARC_CTL_WINFLAG]) begin
            next_windowMatchFlag = 1'b0;
          end
        end
        `SARC_ADDR_CONFIG: begin
          next_clockDividerField = pwdata[`SARC_CFG_DIV_LSB +: 5];
          next_burstModeEnable = pwdata[`SARC_CFG_BURST];
        end
        `SARC_ADDR_ACCUM: begin
          next_justifyShiftField = pwdata[`SARC_ACC_SJST_LSB +: 3];
          next_repeatCountField = pwdata[`SARC_ACC_RPT_LSB +: 3];
        end
        `SARC_ADDR_GT: next_gtThr = pwdata[15:0];
        `SARC_ADDR_LT: next_ltThr = pwdata[15:0];
        default: ;
      endcase
    end
    // Hardware set wins over a software clear in the same cycle
    if (setDone) begin
      next_conversionDoneFlag = 1'b1; // see [R10] see [R11]
    end
    if (setWindow) begin
      next_windowMatchFlag = 1'b1; // see [R14] see [R15]
    end
    if (psel & penable & ~pready) begin
      unique case (paddr)
        `SARC_ADDR_CONTROL: begin
          next_prdata[`SARC_CTL_MODE_LSB +: 3] = startMode;
          next_prdata[`SARC_CTL_WINSEL] = winOutside;
          next_prdata[`SARC_CTL_BUSY] = conversionBusyBit;
          next_prdata[`SARC_CTL_WINFLAG] = windowMatchFlag;
          next_prdata[`SARC_CTL_DONE] = conversionDoneFlag;
        end
        `SARC_ADDR_CONFIG: begin
          next_prdata[`SARC_CFG_DIV_LSB +: 5] = clockDividerField;
          next_prdata[`SARC_CFG_BURST] = burstModeEnable;
        end
        `SARC_ADDR_ACCUM: begin
          next_prdata[`SARC_ACC_SJST_LSB +: 3] = justifyShiftField;
          next_prdata[`SARC_ACC_RPT_LSB +: 3] = repeatCountField;
        end
        `SARC_ADDR_RESULT: next_prdata[15:0] = result; // see [R10]
        `SARC_ADDR_GT: next_prdata[15:0] = gtThr;
        `SARC_ADDR_LT: next_prdata[15:0] = ltThr;
        default: next_pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      startMode <= `SARC_RST_MODE;
      winOutside <= 1'b0;
      clockDividerField <= `SARC_RST_DIV;
      burstModeEnable <= 1'b0;
      justifyShiftField <= `SARC_RST_SJST;
      repeatCountField <= `SARC_RST_RPT;
      gtThr <= `SARC_RST_GT;
      ltThr <= `SARC_RST_LT;
      conversionDoneFlag <= 1'b0;
      windowMatchFlag <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      startMode <= next_startMode;
      winOutside <= next_winOutside;
      clockDividerField <= next_clockDividerField;
      burstModeEnable <= next_burstModeEnable;
      justifyShiftField <= next_justifyShiftField;
      repeatCountField <= next_repeatCountField;
      gtThr <= next_gtThr;
      ltThr <= next_ltThr;
      conversionDoneFlag <= next_conversionDoneFlag;
      windowMatchFlag <= next_windowMatchFlag;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end
endmodule : sarc_top

/* File: verification/sarc_top_asserts.sv */
/*
  Checker for the converter control top: start sources, busy and done
  sequencing, conversion clock half period.
  Assumes binding to sarc_top and the constants header on the path.
*/
`include "sarc_defines.svh"
module sarc_top_asserts (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // Start sources
  input wire logic timer0Ovf,
  input wire logic timer2LowOvf,
  input wire logic timer2HighOvf,
  input wire logic timer2Split,
  input wire logic timer3LowOvf,
  input wire logic timer3HighOvf,
  input wire logic timer3Split,
  input wire logic externalStartInput,
  // Outputs
  input wire logic convStart,
  input wire logic conversionClock,
  input wire logic conversionBusyBit,
  input wire logic conversionDoneFlag
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic wrEdge;
  logic [2:0] mode, next_mode;
  logic [4:0] divReg, next_divReg;
  logic burstReg, next_burstReg, ccPrev, ccSeen, next_ccSeen;
  logic [5:0] ccCnt, next_ccCnt;
  assign wrEdge = psel && penable && pready && pwrite;
  // Shadow of mode and divider, half-period counter
  always_comb begin
    next_mode = mode;
    next_divReg = divReg;
    next_burstReg = burstReg;
    if (wrEdge && paddr == `SARC_ADDR_CONTROL) next_mode = pwdata[2:0];
    if (wrEdge && paddr == `SARC_ADDR_CONFIG) begin
      next_divReg = pwdata[4:0];
      next_burstReg = pwdata[8];
    end
    next_ccSeen = ccSeen;
    next_ccCnt = ccCnt + 6'h01;
    if (!conversionBusyBit) begin
      next_ccSeen = 1'b0;
      next_ccCnt = 6'h00;
    end else if (conversionClock != ccPrev) begin
      next_ccSeen = 1'b1;
      next_ccCnt = 6'h00;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mode <= `SARC_RST_MODE;
      divReg <= `SARC_RST_DIV;
      burstReg <= 1'b0;
      ccSeen <= 1'b0;
      ccCnt <= 6'h00;
      ccPrev <= 1'b0;
    end else begin
      mode <= next_mode;
      divReg <= next_divReg;
      burstReg <= next_burstReg;
      ccSeen <= next_ccSeen;
      ccCnt <= next_ccCnt;
      ccPrev <= conversionClock;
    end
  end
  property p_soft_start;
    wrEdge && paddr == `SARC_ADDR_CONTROL && pwdata[`SARC_CTL_BUSY] &&
      pwdata[2:0] == `SARC_MODE_SOFT && mode == `SARC_MODE_SOFT &&
      !conversionBusyBit |=> convStart && conversionBusyBit;
  endproperty
  a_soft_start: assert property (p_soft_start)
    else $error("soft start not taken");
  property p_tmr0;
    mode == `SARC_MODE_TMR0 && !conversionBusyBit && timer0Ovf |=> convStart;
  endproperty
  a_tmr0: assert property (p_tmr0)
    else $error("timer 0 start not taken");
  property p_tmr2;
    mode == `SARC_MODE_TMR2 && !conversionBusyBit &&
      (timer2Split ? timer2LowOvf : timer2HighOvf) |=> convStart;
  endproperty
  a_tmr2: assert property (p_tmr2)
    else $error("timer 2 start not taken");
  property p_tmr3;
    mode == `SARC_MODE_TMR3 && !conversionBusyBit &&
      (timer3Split ? timer3LowOvf : timer3HighOvf) |=> convStart;
  endproperty
  a_tmr3: assert property (p_tmr3)
    else $error("timer 3 start not taken");
  property p_ext;
    $rose(externalStartInput) && mode == `SARC_MODE_EXT &&
      !conversionBusyBit |-> ##[2:5] convStart;
  endproperty
  a_ext: assert property (p_ext)
    else $error("external start not taken");
  property p_busy_start;
    $rose(conversionBusyBit) |-> convStart;
  endproperty
  a_busy_start: assert property (p_busy_start)
    else $error("busy rose without start");
  property p_start_busy;
    convStart |-> conversionBusyBit;
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("start outside busy");
  property p_done_set;
    $fell(conversionBusyBit) |-> conversionDoneFlag;
  endproperty
  a_done_set: assert property (p_done_set)
    else $error("done not set at busy fall");
  property p_done_cause;
    $rose(conversionDoneFlag) |-> $fell(conversionBusyBit);
  endproperty
  a_done_cause: assert property (p_done_cause)
    else $error("done rose without busy fall");
  property p_half_period;
    conversionBusyBit && !burstReg && ccSeen && conversionClock != ccPrev
      |-> ccCnt == {1'b0, divReg};
  endproperty
  a_half_period: assert property (p_half_period)
    else $error("conversion clock half period wrong");
  c_done: cover property ($fell(conversionBusyBit));
  c_burst: cover property (burstReg && $fell(conversionBusyBit));
  c_ext: cover property (mode == `SARC_MODE_EXT && convStart);
endmodule : sarc_top_asserts
bind sarc_top sarc_top_asserts chk_u (.clk_sys, .reset, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .timer0Ovf, .timer2LowOvf,
  .timer2HighOvf, .timer2Split, .timer3LowOvf, .timer3HighOvf,
  .timer3Split, .externalStartInput, .convStart, .conversionClock,
  .conversionBusyBit, .conversionDoneFlag);

/* File: verification/sarc_far_model.sv */
/*
  Far side: timers, external start pin, low-power oscillator, core code.
  Assumes the bench sets code and calls pulse; timer 2 is in 8-bit mode,
  timer 3 in 16-bit mode.
*/
module sarc_far_model (
  // Clock and status
  input wire logic clk_sys,
  input wire logic conversionBusyBit,
  // Start sources
  output logic timer0Ovf,
  output logic timer2LowOvf,
  output logic timer2HighOvf,
  output logic timer2Split,
  output logic timer3LowOvf,
  output logic timer3HighOvf,
  output logic timer3Split,
  output logic externalStartInput,
  // Oscillator and core
  output logic lpOscIn,
  output logic [9:0] adcCode
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] code = 10'h000;
  logic [5:0] pulses = 6'h00;
  assign {externalStartInput, timer3HighOvf, timer3LowOvf, timer2HighOvf,
    timer2LowOvf, timer0Ovf} = pulses;
  // Code only meaningful during a conversion
  assign adcCode = conversionBusyBit ? code : ~code;
  initial begin
    timer2Split = 1'b1;
    timer3Split = 1'b0;
    lpOscIn = 1'b0;
    forever #36 lpOscIn = ~lpOscIn;
  end
  // Index 5 is the pin, held a few cycles; timers are one-cycle pulses
  task pulse(input int n);
    @(posedge clk_sys);
    pulses[n] <= 1'b1;
    repeat (n == 5 ? 5 : 1) @(posedge clk_sys);
    pulses[n] <= 1'b0;
  endtask : pulse
endmodule : sarc_far_model

/* File: verification/sar_adc_result_and_trigger_control_tb.sv */
/*
  Bench: APB sequences for formatting, accumulation, window, triggers.
  Assumes the checker bound to sarc_top and the far-side model.
*/
`include "sarc_defines.svh"
module sar_adc_result_and_trigger_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, reset, psel, penable, pwrite, pready, pslverr, err, winSel;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic timer0Ovf, timer2LowOvf, timer2HighOvf, timer2Split, timer3LowOvf;
  logic timer3HighOvf, timer3Split, externalStartInput, lpOscIn;
  logic [9:0] adcCode;
  logic convStart, conversionClock, conversionBusyBit, conversionDoneFlag;
  logic windowMatchFlag;
  int numErrors = 0, checksDone = 0, cycles = 0;
  sarc_top dut_u (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .timer0Ovf, .timer2LowOvf,
    .timer2HighOvf, .timer2Split, .timer3LowOvf, .timer3HighOvf,
    .timer3Split, .externalStartInput, .lpOscIn, .adcCode, .convStart,
    .conversionClock, .conversionBusyBit, .conversionDoneFlag,
    .windowMatchFlag);
  sarc_far_model far_u (.clk_sys, .conversionBusyBit, .timer0Ovf,
    .timer2LowOvf, .timer2HighOvf, .timer2Split, .timer3LowOvf,
    .timer3HighOvf, .timer3Split, .externalStartInput, .lpOscIn, .adcCode);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task give_verdict;
    $display("errors %0d checks %0d", numErrors, checksDone);
    if (numErrors == 0 && checksDone > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      numErrors++;
      give_verdict;
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      numErrors++;
      $display("MISMATCH %0t saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rdchk
  task clear_flags;
    apb(1'b1, `SARC_ADDR_CONTROL, {28'h0, winSel, 3'h0});
  endtask : clear_flags
  task wait_done;
    do apb(1'b0, `SARC_ADDR_CONTROL, 32'h0);
    while (rd[`SARC_CTL_DONE] !== 1'b1);
  endtask : wait_done
  task run_set(input logic [9:0] code, input logic [2:0] sj,
    input logic [2:0] rp, input logic [15:0] exp, input logic w);
    far_u.code <= code;
    apb(1'b1, `SARC_ADDR_ACCUM, {26'h0, rp, sj});
    apb(1'b1, `SARC_ADDR_CONTROL, {28'h1, winSel, 3'h0});
    check(32'(conversionBusyBit), 32'h1);
    check(32'(conversionDoneFlag), 32'h0);
    wait_done;
    rdchk(`SARC_ADDR_RESULT, {16'h0, exp});
    check(32'(windowMatchFlag), 32'(w));
    clear_flags;
  endtask : run_set
  task trig(input logic [2:0] md, input int bad, input int good);
    apb(1'b1, `SARC_ADDR_CONTROL, {29'h0, md});
    if (bad >= 0) begin
      far_u.pulse(bad);
      repeat (8) @(posedge clk_sys);
      check(32'(conversionBusyBit), 32'h0);
    end
    far_u.pulse(good);
    wait_done;
    rdchk(`SARC_ADDR_RESULT, 32'h0155);
    clear_flags;
  endtask : trig
  initial begin
    {psel, penable, pwrite, paddr, pwdata, winSel} = '0;
    reset = 1'b1;
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    rdchk(`SARC_ADDR_CONTROL, 32'h0);
    rdchk(`SARC_ADDR_CONFIG, 32'(`SARC_RST_DIV));
    rdchk(`SARC_ADDR_ACCUM, 32'h0);
    rdchk(`SARC_ADDR_GT, 32'(`SARC_RST_GT));
    rdchk(`SARC_ADDR_LT, 32'(`SARC_RST_LT));
    apb(1'b1, `SARC_ADDR_RESULT, 32'h1234);
    rdchk(`SARC_ADDR_RESULT, 32'h0);
    rdchk(8'h18, 32'h0);
    check(32'(err), 32'h1);
    run_set(10'h3FF, 3'h0, 3'h0, 16'h03FF, 1'b0);
    apb(1'b1, `SARC_ADDR_CONFIG, 32'h0);
    run_set(10'h3FF, 3'h4, 3'h0, 16'hFFC0, 1'b0);
    run_set(10'h200, 3'h4, 3'h0, 16'h8000, 1'b0);
    run_set(10'h100, 3'h0, 3'h0, 16'h0100, 1'b0);
    // Accumulating sets keep right justification
    run_set(10'h3FF, 3'h0, 3'h1, 16'h0FFC, 1'b0);
    run_set(10'h1FF, 3'h0, 3'h3, 16'h1FF0, 1'b0);
    run_set(10'h3FF, 3'h0, 3'h5, 16'hFFC0, 1'b0);
    run_set(10'h3FF, 3'h1, 3'h1, 16'h07FE, 1'b0);
    run_set(10'h200, 3'h2, 3'h2, 16'h0400, 1'b0);
    run_set(10'h3FF, 3'h3, 3'h4, 16'h0FFC, 1'b0);
    apb(1'b1, `SARC_ADDR_GT, 32'h40);
    apb(1'b1, `SARC_ADDR_LT, 32'h80);
    run_set(10'h040, 3'h0, 3'h0, 16'h0040, 1'b0);
    run_set(10'h080, 3'h0, 3'h0, 16'h0080, 1'b0);
    run_set(10'h060, 3'h0, 3'h0, 16'h0060, 1'b1);
    winSel = 1'b1;
    run_set(10'h03F, 3'h0, 3'h0, 16'h003F, 1'b1);
    run_set(10'h040, 3'h0, 3'h0, 16'h0040, 1'b0);
    run_set(10'h080, 3'h0, 3'h0, 16'h0080, 1'b0);
    run_set(10'h081, 3'h0, 3'h0, 16'h0081, 1'b1);
    run_set(10'h040, 3'h4, 3'h0, 16'h1000, 1'b1);
    winSel = 1'b0;
    apb(1'b1, `SARC_ADDR_ACCUM, 32'h0);
    far_u.code <= 10'h155;
    trig(`SARC_MODE_TMR0, -1, 0);
    trig(`SARC_MODE_TMR2, 2, 1);
    trig(`SARC_MODE_TMR3, 3, 4);
    // Pin taken as skipped by the port routing
    trig(`SARC_MODE_EXT, -1, 5);
    apb(1'b1, `SARC_ADDR_CONFIG, 32'h100);
    run_set(10'h155, 3'h0, 3'h0, 16'h0155, 1'b0);
    give_verdict;
  end
endmodule : sar_adc_result_and_trigger_control_tb
